//--- hw/srlt_top.sv
/*
  SDR read latency table, rows for 80, 90, 104 and 133 MHz.
  Two views: a per-command lookup by latency code and SCK frequency, and a
  byte read port returning the raw table bytes at their parameter offsets.
  Assumes requests come from logic on clk; all outputs are registered.
*/
// Summary of operation
// - An all-ones mode or latency byte marks the command unsupported in that band.
// - Row for code 01b covers up to 90 MHz; plain read unsupported there.
// - Code 01b: fast, dual-out, quad-out 0/8 cycles; dual I/O 0/5.
// - Quad I/O uses two mode cycles; latency 4 under 00b/01b, 5 under 10b to 104 MHz.
// - Code 10b to 104 MHz: no plain read; 0/8 outputs; dual I/O 0/6.
// - Code 10b to 133 MHz: only fast read, 0/8; all else unsupported.
// - 80 MHz band: fast, dual-out, quad-out 0/8; dual I/O 0/4.
// - 80 MHz band uses code 00b; plain read unsupported there.
`timescale 1ns/1ps
`include "srlt_regs.svh"

module srlt_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        lookup_req,
  input  wire logic [1:0]  lookup_code,
  input  wire logic [7:0]  lookup_freq_mhz,
  input  wire logic [2:0]  lookup_cmd,
  output logic             lookup_done,
  output logic [7:0]       lookup_mode,
  output logic [7:0]       lookup_lat,
  output logic             lookup_unsup,
  input  wire logic        byte_req,
  input  wire logic [6:0]  byte_addr,
  output logic             byte_done,
  output logic [7:0]       byte_data
);

  srlt_pkg::srlt_band_type band;
  srlt_pkg::srlt_cmd_type  cmd;
  logic [7:0]              row_mode;
  logic [7:0]              row_lat;
  logic                    sel_ok;
  logic [7:0]              next_byte;
  srlt_pkg::srlt_band_type byte_band;
  srlt_pkg::srlt_cmd_type  byte_cmd;
  logic [7:0]              byte_mode;
  logic [7:0]              byte_lat;
  logic [6:0]              rel;
  logic [6:0]              base;

  // Band chosen from code and frequency; a frequency beyond the code's row is refused
  always_comb begin
    band   = srlt_pkg::SRLT_BAND_80;
    sel_ok = 1'b0;
    unique case (lookup_code)
      `SRLT_LC_80: begin
        band   = srlt_pkg::SRLT_BAND_80;
        sel_ok = (lookup_freq_mhz <= `SRLT_F80);
      end
      `SRLT_LC_90: begin
        band   = srlt_pkg::SRLT_BAND_90;
        sel_ok = (lookup_freq_mhz <= `SRLT_F90);
      end
      `SRLT_LC_104: begin
        band   = (lookup_freq_mhz <= `SRLT_F104) ? srlt_pkg::SRLT_BAND_104 : srlt_pkg::SRLT_BAND_133;
        sel_ok = (lookup_freq_mhz <= `SRLT_F133);
      end
      default: begin
        band   = srlt_pkg::SRLT_BAND_80;
        sel_ok = 1'b0;
      end
    endcase
    cmd = (lookup_cmd <= 3'h5) ? srlt_pkg::srlt_cmd_type'(lookup_cmd) : srlt_pkg::SRLT_CMD_READ;
    if (lookup_cmd > 3'h5) begin
      sel_ok = 1'b0;
    end
  end

  srlt_row u_lookup_row (
    .band        (band),
    .cmd         (cmd),
    .mode_cycles (row_mode),
    .lat_cycles  (row_lat)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lookup_done  <= 1'b0;
      lookup_mode  <= `SRLT_UNSUP;
      lookup_lat   <= `SRLT_UNSUP;
      lookup_unsup <= 1'b0;
    end else begin
      lookup_done <= lookup_req;
      if (lookup_req) begin
        lookup_mode  <= sel_ok ? row_mode : `SRLT_UNSUP;
        lookup_lat   <= sel_ok ? row_lat : `SRLT_UNSUP;
        lookup_unsup <= !sel_ok || (row_mode == `SRLT_UNSUP) || (row_lat == `SRLT_UNSUP);
      end
    end
  end

  // Raw byte view of rows 3 to 6 at their parameter offsets
  always_comb begin
    byte_band = srlt_pkg::SRLT_BAND_80;
    base      = `SRLT_ROW3_OFS;
    if (byte_addr >= `SRLT_ROW6_OFS) begin
      byte_band = srlt_pkg::SRLT_BAND_133;
      base      = `SRLT_ROW6_OFS;
    end else if (byte_addr >= `SRLT_ROW5_OFS) begin
      byte_band = srlt_pkg::SRLT_BAND_104;
      base      = `SRLT_ROW5_OFS;
    end else if (byte_addr >= `SRLT_ROW4_OFS) begin
      byte_band = srlt_pkg::SRLT_BAND_90;
      base      = `SRLT_ROW4_OFS;
    end
    rel      = 7'(byte_addr - base);
    byte_cmd = (rel >= 7'h2 && rel < `SRLT_ROW_LEN) ? srlt_pkg::srlt_cmd_type'(3'((rel - 7'h2) >> 1))
                                                     : srlt_pkg::SRLT_CMD_READ;
  end

  srlt_row u_byte_row (
    .band        (byte_band),
    .cmd         (byte_cmd),
    .mode_cycles (byte_mode),
    .lat_cycles  (byte_lat)
  );

  always_comb begin
    next_byte = 8'h00;
    if (byte_addr >= `SRLT_ROW3_OFS && byte_addr <= `SRLT_LAST_OFS) begin
      if (rel == 7'h0) begin
        unique case (byte_band)
          srlt_pkg::SRLT_BAND_80:  next_byte = `SRLT_F80;
          srlt_pkg::SRLT_BAND_90:  next_byte = `SRLT_F90;
          srlt_pkg::SRLT_BAND_104: next_byte = `SRLT_F104;
          srlt_pkg::SRLT_BAND_133: next_byte = `SRLT_F133;
        endcase
      end else if (rel == 7'h1) begin
        next_byte = (byte_band == srlt_pkg::SRLT_BAND_133) ? {6'h00, `SRLT_LC_104} : {6'h00, byte_band};
      end else begin
        next_byte = rel[0] ? byte_lat : byte_mode;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_done <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_done <= byte_req;
      if (byte_req) begin
        byte_data <= next_byte;
      end
    end
  end

endmodule : srlt_top

//--- hw/srlt_regs.svh
/*
  Constants for the SDR read latency table: byte offsets of the table rows,
  the row contents, the unsupported marker and the latency codes.
  Assumes nothing; definitions only.
*/
`ifndef SRLT_REGS_SVH
`define SRLT_REGS_SVH

// Unsupported marker for a mode or latency count
`define SRLT_UNSUP          8'hff
// Latency codes
`define SRLT_LC_80          2'h0
`define SRLT_LC_90          2'h1
`define SRLT_LC_104         2'h2
// Frequency limits in MHz, as stored in each row's first byte
`define SRLT_F80            8'h50
`define SRLT_F90            8'h5a
`define SRLT_F104           8'h68
`define SRLT_F133           8'h85
// Row start offsets within the parameter, and row length
`define SRLT_ROW3_OFS       7'h20
`define SRLT_ROW4_OFS       7'h2e
`define SRLT_ROW5_OFS       7'h3c
`define SRLT_ROW6_OFS       7'h4a
`define SRLT_ROW_LEN        7'h0e
`define SRLT_LAST_OFS       7'h57
// Cycle counts
`define SRLT_MODE0          8'h00
`define SRLT_MODE2          8'h02
`define SRLT_LAT4           8'h04
`define SRLT_LAT5           8'h05
`define SRLT_LAT6           8'h06
`define SRLT_LAT8           8'h08

`endif

//--- hw/srlt_pkg.sv
/*
  Types for the SDR read latency table.
  Assumes srlt_regs.svh supplies the numeric constants.
*/
package srlt_pkg;

  // Read command families, in table column order
  typedef enum logic [2:0] {
    SRLT_CMD_READ  = 3'h0,
    SRLT_CMD_FAST  = 3'h1,
    SRLT_CMD_DOUT  = 3'h2,
    SRLT_CMD_QOUT  = 3'h3,
    SRLT_CMD_DIO   = 3'h4,
    SRLT_CMD_QIO   = 3'h5
  } srlt_cmd_type;

  // Frequency bands covered by this block
  typedef enum logic [1:0] {
    SRLT_BAND_80   = 2'h0,
    SRLT_BAND_90   = 2'h1,
    SRLT_BAND_104  = 2'h2,
    SRLT_BAND_133  = 2'h3
  } srlt_band_type;

endpackage : srlt_pkg

//--- hw/srlt_row.sv
/*
  One row of the latency table as combinational lookup: for a band and a
  read command gives mode and latency counts; all-ones means unsupported.
  Assumes the band and command are legal codes from srlt_pkg.
*/
`timescale 1ns/1ps
`include "srlt_regs.svh"

module srlt_row (
  input  wire srlt_pkg::srlt_band_type band,
  input  wire srlt_pkg::srlt_cmd_type  cmd,
  output logic [7:0]                   mode_cycles,
  output logic [7:0]                   lat_cycles
);

  always_comb begin
    mode_cycles = `SRLT_UNSUP;
    lat_cycles  = `SRLT_UNSUP;
    unique case (band)
      srlt_pkg::SRLT_BAND_80, srlt_pkg::SRLT_BAND_90, srlt_pkg::SRLT_BAND_104: begin
        unique case (cmd)
          srlt_pkg::SRLT_CMD_READ: begin
            mode_cycles = `SRLT_UNSUP;
            lat_cycles  = `SRLT_UNSUP;
          end
          srlt_pkg::SRLT_CMD_FAST, srlt_pkg::SRLT_CMD_DOUT, srlt_pkg::SRLT_CMD_QOUT: begin
            mode_cycles = `SRLT_MODE0;
            lat_cycles  = `SRLT_LAT8;
          end
          srlt_pkg::SRLT_CMD_DIO: begin
            mode_cycles = `SRLT_MODE0;
            if (band == srlt_pkg::SRLT_BAND_80) begin
              lat_cycles = `SRLT_LAT4;
            end else if (band == srlt_pkg::SRLT_BAND_90) begin
              lat_cycles = `SRLT_LAT5;
            end else begin
              lat_cycles = `SRLT_LAT6;
            end
          end
          srlt_pkg::SRLT_CMD_QIO: begin
            mode_cycles = `SRLT_MODE2;
            lat_cycles  = (band == srlt_pkg::SRLT_BAND_104) ? `SRLT_LAT5 : `SRLT_LAT4;
          end
          default: begin
            mode_cycles = `SRLT_UNSUP;
            lat_cycles  = `SRLT_UNSUP;
          end
        endcase
      end
      srlt_pkg::SRLT_BAND_133: begin
        if (cmd == srlt_pkg::SRLT_CMD_FAST) begin
          mode_cycles = `SRLT_MODE0;
          lat_cycles  = `SRLT_LAT8;
        end
      end
    endcase
  end

endmodule : srlt_row

//--- sim/srlt_chk.sv
/*
  Checker for srlt_top, attached by bind.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module srlt_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       lookup_req,
  input wire logic [1:0] lookup_code,
  input wire logic [7:0] lookup_freq_mhz,
  input wire logic [2:0] lookup_cmd,
  input wire logic       lookup_done,
  input wire logic [7:0] lookup_mode,
  input wire logic [7:0] lookup_lat,
  input wire logic       lookup_unsup,
  input wire logic       byte_req,
  input wire logic [6:0] byte_addr,
  input wire logic       byte_done,
  input wire logic [7:0] byte_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_done_follows_req: assert property (lookup_req |=> lookup_done) else $error("lookup done missing");
  a_done_has_cause: assert property (lookup_done |-> $past(lookup_req)) else $error("lookup done unasked");
  a_byte_done_timing: assert property (byte_req |=> byte_done ##1 (byte_done == $past(byte_req)))
    else $error("byte done timing");
  a_result_holds: assert property (!lookup_req |=> $stable(lookup_mode) && $stable(lookup_lat))
    else $error("lookup result moved");
  a_marker_flags: assert property (lookup_done |-> lookup_unsup == (lookup_mode == 8'hff || lookup_lat == 8'hff))
    else $error("unsupported flag wrong");
  a_plain_read_off: assert property (lookup_req && lookup_cmd == 3'h0 |=> lookup_unsup)
    else $error("plain read allowed");
  a_quad_io_mode: assert property (lookup_req && lookup_cmd == 3'h5 && lookup_code != 2'h3
    && lookup_freq_mhz <= 8'h50 |=> lookup_mode == 8'h02) else $error("quad io mode wrong");
  a_fast_high_band: assert property (lookup_req && lookup_cmd == 3'h1 && lookup_code == 2'h2
    && lookup_freq_mhz <= 8'h85 |=> lookup_mode == 8'h00 && lookup_lat == 8'h08) else $error("fast read wrong");
  a_byte_holds: assert property (!byte_req |=> $stable(byte_data)) else $error("byte data moved");
endmodule : srlt_chk

//--- sim/srlt_host.sv
/*
  Host controller model driving the lookup port.
  Assumes go, pick and the request fields change after the clock edge.
*/
`timescale 1ns/1ps
module srlt_host (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       pick,
  input  wire logic [1:0] code,
  input  wire logic [7:0] freq,
  input  wire logic [2:0] cmd,
  output logic            lookup_req,
  output logic [1:0]      lookup_code,
  output logic [7:0]      lookup_freq_mhz,
  output logic [2:0]      lookup_cmd
);
  initial {lookup_req, lookup_code, lookup_freq_mhz, lookup_cmd} = 14'h0;
  always @(posedge clk) begin
    lookup_req <= go;
    // Idle frequency and command fields toggle so nothing leans on stale values
    lookup_freq_mhz <= go ? freq : ~lookup_freq_mhz;
    lookup_cmd <= go ? cmd : ~lookup_cmd;
    lookup_code <= !pick ? code : freq <= 8'h50 ? 2'h0 : freq <= 8'h5a ? 2'h1 : 2'h2;
  end
endmodule : srlt_host

//--- sim/srlt_top_bench.sv
/*
  Self-checking bench for srlt_top against a table model.
  Assumes srlt_host and srlt_chk are compiled first.
*/
`timescale 1ns/1ps
module srlt_top_bench;
  logic clk = 0, rst_n = 0, go = 0, pick = 0, byte_req = 0, lookup_req, lookup_done, lookup_unsup, byte_done;
  logic [1:0] code = 0, lookup_code;
  logic [2:0] cmd = 0, lookup_cmd;
  logic [6:0] byte_addr = 0;
  logic [7:0] freq = 0, lookup_freq_mhz, lookup_mode, lookup_lat, byte_data;
  logic [16:0] lq[$], bq[$], e;
  int errors = 0, tests_run = 0, fl[8] = '{80, 81, 90, 91, 104, 105, 133, 134};
  always #12.5 clk = ~clk;
  srlt_host u_srlt_host (.clk(clk), .go(go), .pick(pick), .code(code), .freq(freq), .cmd(cmd),
    .lookup_req(lookup_req), .lookup_code(lookup_code), .lookup_freq_mhz(lookup_freq_mhz), .lookup_cmd(lookup_cmd));
  srlt_top u_srlt_top (.clk(clk), .rst_n(rst_n), .lookup_req(lookup_req), .lookup_code(lookup_code),
    .lookup_freq_mhz(lookup_freq_mhz), .lookup_cmd(lookup_cmd), .lookup_done(lookup_done), .lookup_mode(lookup_mode),
    .lookup_lat(lookup_lat), .lookup_unsup(lookup_unsup), .byte_req(byte_req), .byte_addr(byte_addr),
    .byte_done(byte_done), .byte_data(byte_data));
  function automatic logic [7:0] exp_byte(int a);
    int r, i, c;
    if (a < 32 || a > 87) return 8'h00;
    r = (a - 32) / 14;
    i = (a - 32) % 14;
    c = i / 2 - 1;
    if (i == 0) return r == 0 ? 8'h50 : r == 1 ? 8'h5a : r == 2 ? 8'h68 : 8'h85;
    if (i == 1) return r == 3 ? 8'h02 : r[7:0];
    if (c == 0 || (r == 3 && c != 1)) return 8'hff;
    if (i % 2 == 0) return c == 5 ? 8'h02 : 8'h00;
    if (c < 4) return 8'h08;
    return c == 5 ? (r == 2 ? 8'h05 : 8'h04) : 8'h04 + r[7:0];
  endfunction : exp_byte
  function automatic logic [16:0] exp_look(int c, int f, int m);
    logic [7:0] md, lt;
    if (c == 3 || m > 5 || f > (c == 0 ? 80 : c == 1 ? 90 : 133)) return 17'h1ffff;
    md = exp_byte(34 + 14 * (c == 2 && f > 104 ? 3 : c) + 2 * m);
    lt = exp_byte(35 + 14 * (c == 2 && f > 104 ? 3 : c) + 2 * m);
    return {md == 8'hff || lt == 8'hff, md, lt};
  endfunction : exp_look
  task automatic check(string n, logic [16:0] x, logic [16:0] s);
    tests_run++;
    if (x !== s) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    if (lookup_done === 1'b1) begin
      e = lq.pop_front();
      check("lookup", e, {lookup_unsup, lookup_mode, lookup_lat});
    end
    if (byte_done === 1'b1) begin
      e = bq.pop_front();
      check("byte", e, {9'h0, byte_data});
    end
    if (lookup_req && rst_n) lq.push_back(exp_look(lookup_code, lookup_freq_mhz, lookup_cmd));
    if (byte_req && rst_n) bq.push_back({9'h0, exp_byte(byte_addr)});
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'he838));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 check("reset", 17'h0ffff, {lookup_unsup, lookup_mode, lookup_lat});
    check("reset flags", 17'h0, {7'h0, lookup_done, byte_done, byte_data});
    for (int k = 0; k < 256; k++) begin
      @(posedge clk);
      {go, pick, byte_req, byte_addr} <= {3'b101, k[6:0]};
      {code, cmd, freq} <= {k[1:0], k[4:2], fl[k[7:5]][7:0]};
    end
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      {go, pick, byte_req, byte_addr, code, cmd} <= 15'($urandom);
      freq <= 8'($urandom % 150);
    end
    @(posedge clk);
    {go, byte_req} <= 2'b00;
    repeat (3) @(posedge clk);
    check("pending", 17'h0, 17'(lq.size() + bq.size()));
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 check("reset again", 17'h0ffff, {lookup_unsup, lookup_mode, lookup_lat});
    check("reset again flags", 17'h0, {7'h0, lookup_done, byte_done, byte_data});
    summarize();
  end
endmodule : srlt_top_bench
bind srlt_top srlt_chk u_chk (.clk(clk), .rst_n(rst_n), .lookup_req(lookup_req), .lookup_code(lookup_code),
  .lookup_freq_mhz(lookup_freq_mhz), .lookup_cmd(lookup_cmd), .lookup_done(lookup_done), .lookup_mode(lookup_mode),
  .lookup_lat(lookup_lat), .lookup_unsup(lookup_unsup), .byte_req(byte_req), .byte_addr(byte_addr),
  .byte_done(byte_done), .byte_data(byte_data));
